// ### hdl/afi_dsfid_pkg.sv
// constants and types for the afi/dsfid write and lock command handler
package afi_dsfid_pkg;
	localparam logic [7:0]  CMD_WRITE_AFI    = 8'h27;
	localparam logic [7:0]  CMD_LOCK_AFI     = 8'h28;
	localparam logic [7:0]  CMD_WRITE_DSFID  = 8'h29;
	localparam logic [7:0]  CMD_LOCK_DSFID   = 8'h2A;
	localparam logic [7:0]  ERR_ALREADY_LOCK = 8'h11;
	localparam logic [7:0]  ERR_LOCKED       = 8'h12;
	localparam logic [7:0]  ERR_PROG_FAIL    = 8'h13;
	localparam logic [7:0]  ERR_LOCK_FAIL    = 8'h14;
	localparam logic [7:0]  ERR_NONE         = 8'h00;
	localparam logic [7:0]  RESP_OK          = 8'h00;
	localparam logic [7:0]  RESP_ERR         = 8'h01;
	localparam int          FLAG_ADDR_BIT    = 5;
	localparam int          FLAG_OPT_BIT     = 6;
	localparam logic [15:0] CRC_INIT         = 16'hFFFF;
	localparam logic [15:0] CRC_POLY         = 16'h8408;
	localparam logic [15:0] CRC_RESIDUE      = 16'hF0B8;
	localparam logic [7:0]  AFI_RESET        = 8'h00;
	localparam logic [7:0]  DSFID_RESET      = 8'h00;
	// frame byte positions and lengths
	localparam logic [3:0]  POS_FLAGS        = 4'h0;
	localparam logic [3:0]  POS_CMD          = 4'h1;
	localparam logic [3:0]  POS_UID          = 4'h2;
	localparam logic [3:0]  POS_DATA_ADDR    = 4'hA;
	localparam logic [3:0]  LEN_BASE         = 4'h4;
	localparam logic [3:0]  LEN_UID          = 4'h8;
	localparam logic [3:0]  LEN_DATA         = 4'h1;
	localparam int          RX_DEPTH         = 12;
	localparam logic [2:0]  LEN_RESP_OK      = 3'h3;
	localparam logic [2:0]  LEN_RESP_ERR     = 3'h4;
	// timing
	localparam int          CLK_PERIOD_NS    = 4;
	localparam int          NOMINAL_RESPONSE_DELAY_NS = 320900;
	localparam int          WRITE_PERIOD_NS  = 302000;
	localparam int          WRITE_PERIODS    = 18;
	localparam int          RF_WRITE_CYCLE_TIME_NS =
		NOMINAL_RESPONSE_DELAY_NS + WRITE_PERIODS * WRITE_PERIOD_NS;
	localparam int          T1_CYC_DEF = (NOMINAL_RESPONSE_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int          WT_CYC_DEF = (RF_WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int          CYC_W            = 21;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_RX    = 5'h02,
		ST_WAIT  = 5'h04,
		ST_TX    = 5'h08,
		ST_DRAIN = 5'h10
	} state_t;
endpackage : afi_dsfid_pkg

// ### hdl/rf_afi_dsfid_write_lock.sv
// afi/dsfid write and lock command handler with activity pin
`timescale 1ns/1ns
module rf_afi_dsfid_write_lock #(
	parameter int T1_CYC = afi_dsfid_pkg::T1_CYC_DEF,
	parameter int WT_CYC = afi_dsfid_pkg::WT_CYC_DEF
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        rx_sof_i,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_byte_i,
	input  wire logic        rx_eof_i,
	input  wire logic [63:0] uid_i,
	input  wire logic        busy_mode_i,
	input  wire logic        nvm_fail_i,
	input  wire logic        tx_ready_i,
	output logic             tx_valid_o,
	output logic [7:0]       tx_byte_o,
	output logic             tx_last_o,
	output logic             nvm_prog_o,
	output logic [7:0]       afi_o,
	output logic [7:0]       dsfid_o,
	output logic             afi_locked_o,
	output logic             dsfid_locked_o,
	output logic             rf_activity_output_o,
	output logic             rf_activity_output_oe_n_o
);
	localparam logic [afi_dsfid_pkg::CYC_W-1:0] T1_END = afi_dsfid_pkg::CYC_W'(T1_CYC - 1);
	localparam logic [afi_dsfid_pkg::CYC_W-1:0] WT_END = afi_dsfid_pkg::CYC_W'(WT_CYC - 1);

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ afi_dsfid_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte

	afi_dsfid_pkg::state_t          st_q;
	logic [7:0]                     rxb_q [0:afi_dsfid_pkg::RX_DEPTH-1];
	logic [3:0]                     cnt_q;
	logic [15:0]                    crc_q;
	logic [afi_dsfid_pkg::CYC_W-1:0] cyc_q;
	logic [7:0]                     cmd_q;
	logic [7:0]                     data_q;
	logic                           opt_q;
	logic                           prog_q;
	logic [7:0]                     err_q;
	logic [7:0]                     resp_q [0:3];
	logic [2:0]                     rlen_q;
	logic [2:0]                     ridx_q;
	logic [7:0]                     flags;
	logic [7:0]                     cmd;
	logic                           addr;
	logic                           is_write;
	logic                           is_afi;
	logic [3:0]                     exp_len;
	logic                           frame_ok;
	logic                           prog_end;
	logic                           t1_end;
	logic [7:0]                     lock_err;

	// request decode, evaluated at the request eof
	always_comb begin
		flags    = rxb_q[afi_dsfid_pkg::POS_FLAGS];
		cmd      = rxb_q[afi_dsfid_pkg::POS_CMD];
		addr     = flags[afi_dsfid_pkg::FLAG_ADDR_BIT];
		is_write = (cmd == afi_dsfid_pkg::CMD_WRITE_AFI) || (cmd == afi_dsfid_pkg::CMD_WRITE_DSFID);
		is_afi   = (cmd == afi_dsfid_pkg::CMD_WRITE_AFI) || (cmd == afi_dsfid_pkg::CMD_LOCK_AFI);
		exp_len  = afi_dsfid_pkg::LEN_BASE + (addr ? afi_dsfid_pkg::LEN_UID : 4'h0)
			+ (is_write ? afi_dsfid_pkg::LEN_DATA : 4'h0);
		frame_ok = (crc_q == afi_dsfid_pkg::CRC_RESIDUE)
			&& (cnt_q == exp_len)
			&& (is_write || cmd == afi_dsfid_pkg::CMD_LOCK_AFI
				|| cmd == afi_dsfid_pkg::CMD_LOCK_DSFID)
			&& (!addr || {rxb_q[9], rxb_q[8], rxb_q[7], rxb_q[6], rxb_q[5], rxb_q[4],
				rxb_q[3], rxb_q[2]} == uid_i);
		if (is_write) begin
			lock_err = (is_afi ? afi_locked_o : dsfid_locked_o)
				? afi_dsfid_pkg::ERR_LOCKED : afi_dsfid_pkg::ERR_NONE;
		end else begin
			lock_err = (is_afi ? afi_locked_o : dsfid_locked_o)
				? afi_dsfid_pkg::ERR_ALREADY_LOCK : afi_dsfid_pkg::ERR_NONE;
		end
		t1_end   = (st_q == afi_dsfid_pkg::ST_WAIT) && (cyc_q == T1_END);
		prog_end = prog_q && (cyc_q == WT_END);
	end

	// request capture with running crc; frames outside idle are ignored
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= 4'h0;
			crc_q <= afi_dsfid_pkg::CRC_INIT;
			for (int i = 0; i < afi_dsfid_pkg::RX_DEPTH; i++) begin
				rxb_q[i] <= 8'h00;
			end
		end else if (st_q == afi_dsfid_pkg::ST_IDLE && rx_sof_i) begin
			cnt_q <= 4'h0;
			crc_q <= afi_dsfid_pkg::CRC_INIT;
		end else if (st_q == afi_dsfid_pkg::ST_RX && rx_valid_i) begin
			if (cnt_q < 4'(afi_dsfid_pkg::RX_DEPTH)) begin
				rxb_q[cnt_q] <= rx_byte_i;
			end
			if (cnt_q != 4'hF) begin
				cnt_q <= cnt_q + 4'h1;
			end
			crc_q <= crc_byte(crc_q, rx_byte_i);
		end
	end

	// sequencing of the command
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q <= afi_dsfid_pkg::ST_IDLE;
		end else begin
			case (st_q)
				afi_dsfid_pkg::ST_IDLE: begin
					if (rx_sof_i) begin
						st_q <= afi_dsfid_pkg::ST_RX;
					end
				end
				afi_dsfid_pkg::ST_RX: begin
					if (rx_eof_i) begin
						st_q <= frame_ok ? afi_dsfid_pkg::ST_WAIT : afi_dsfid_pkg::ST_IDLE;
					end
				end
				afi_dsfid_pkg::ST_WAIT: begin
					// a locked error never starts a cycle, so it answers at t1 even with option set
					if ((opt_q ? prog_end : t1_end) || (!prog_q && t1_end)) begin
						st_q <= afi_dsfid_pkg::ST_TX;
					end
				end
				afi_dsfid_pkg::ST_TX: begin
					if (tx_valid_o && tx_ready_i && tx_last_o) begin
						st_q <= (prog_q && !prog_end) ? afi_dsfid_pkg::ST_DRAIN
							: afi_dsfid_pkg::ST_IDLE;
					end
				end
				afi_dsfid_pkg::ST_DRAIN: begin
					// answer already sent; new requests are ignored until the cycle ends
					if (!prog_q || prog_end) begin
						st_q <= afi_dsfid_pkg::ST_IDLE;
					end
				end
				default: st_q <= afi_dsfid_pkg::ST_IDLE;
			endcase
		end
	end

	// command latch and write cycle timer
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_q  <= 8'h00;
			data_q <= 8'h00;
			opt_q  <= 1'b0;
			prog_q <= 1'b0;
			cyc_q  <= '0;
		end else if (st_q == afi_dsfid_pkg::ST_RX && rx_eof_i && frame_ok) begin
			cmd_q  <= cmd;
			data_q <= rxb_q[addr ? afi_dsfid_pkg::POS_DATA_ADDR : afi_dsfid_pkg::POS_UID];
			opt_q  <= flags[afi_dsfid_pkg::FLAG_OPT_BIT];
			prog_q <= (lock_err == afi_dsfid_pkg::ERR_NONE);
			cyc_q  <= '0;
		end else begin
			if (prog_end) begin
				prog_q <= 1'b0;
			end
			if (st_q != afi_dsfid_pkg::ST_IDLE && st_q != afi_dsfid_pkg::ST_RX) begin
				cyc_q <= cyc_q + 1'b1;
			end
		end
	end

	// stored values; committed at the end of the cycle unless programming failed
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			afi_o          <= afi_dsfid_pkg::AFI_RESET;
			dsfid_o        <= afi_dsfid_pkg::DSFID_RESET;
			afi_locked_o   <= 1'b0;
			dsfid_locked_o <= 1'b0;
		end else if (prog_end && !nvm_fail_i) begin
			case (cmd_q)
				afi_dsfid_pkg::CMD_WRITE_AFI:   afi_o <= data_q;
				afi_dsfid_pkg::CMD_LOCK_AFI:    afi_locked_o <= 1'b1;
				afi_dsfid_pkg::CMD_WRITE_DSFID: dsfid_o <= data_q;
				afi_dsfid_pkg::CMD_LOCK_DSFID:  dsfid_locked_o <= 1'b1;
				default: afi_o <= afi_o;
			endcase
		end
	end

	// response build and byte handshake
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		logic [7:0]  e;
		logic [15:0] c;
		e = afi_dsfid_pkg::ERR_NONE;
		c = afi_dsfid_pkg::CRC_INIT;
		if (sys_rst_i) begin
			err_q      <= afi_dsfid_pkg::ERR_NONE;
			rlen_q     <= 3'h0;
			ridx_q     <= 3'h0;
			tx_valid_o <= 1'b0;
			tx_byte_o  <= 8'h00;
			tx_last_o  <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				resp_q[i] <= 8'h00;
			end
		end else if (st_q == afi_dsfid_pkg::ST_RX && rx_eof_i && frame_ok) begin
			err_q <= lock_err;
		end else if (st_q == afi_dsfid_pkg::ST_WAIT
			&& ((opt_q ? prog_end : t1_end) || (!prog_q && t1_end))) begin
			e = err_q;
			if (opt_q && prog_q && nvm_fail_i) begin
				e = (cmd_q == afi_dsfid_pkg::CMD_WRITE_AFI || cmd_q == afi_dsfid_pkg::CMD_WRITE_DSFID)
					? afi_dsfid_pkg::ERR_PROG_FAIL : afi_dsfid_pkg::ERR_LOCK_FAIL;
			end
			err_q <= e;
			if (e == afi_dsfid_pkg::ERR_NONE) begin
				c = ~crc_byte(c, afi_dsfid_pkg::RESP_OK);
				resp_q[0] <= afi_dsfid_pkg::RESP_OK;
				resp_q[1] <= c[7:0];
				resp_q[2] <= c[15:8];
				rlen_q    <= afi_dsfid_pkg::LEN_RESP_OK;
				tx_byte_o <= afi_dsfid_pkg::RESP_OK;
			end else begin
				c = ~crc_byte(crc_byte(c, afi_dsfid_pkg::RESP_ERR), e);
				resp_q[0] <= afi_dsfid_pkg::RESP_ERR;
				resp_q[1] <= e;
				resp_q[2] <= c[7:0];
				resp_q[3] <= c[15:8];
				rlen_q    <= afi_dsfid_pkg::LEN_RESP_ERR;
				tx_byte_o <= afi_dsfid_pkg::RESP_ERR;
			end
			ridx_q     <= 3'h0;
			tx_valid_o <= 1'b1;
			tx_last_o  <= 1'b0;
		end else if (tx_valid_o && tx_ready_i) begin
			if (tx_last_o) begin
				tx_valid_o <= 1'b0;
				tx_last_o  <= 1'b0;
			end else begin
				ridx_q    <= ridx_q + 3'h1;
				tx_byte_o <= resp_q[2'(ridx_q + 3'h1)];
				tx_last_o <= (ridx_q + 3'h2 == rlen_q);
			end
		end
	end

	// activity pin: open drain, driven low while active; one cycle behind the state
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rf_activity_output_o      <= 1'b0;
			rf_activity_output_oe_n_o <= 1'b1;
			nvm_prog_o                <= 1'b0;
		end else begin
			rf_activity_output_o <= 1'b0;
			nvm_prog_o           <= prog_q;
			if (busy_mode_i) begin
				rf_activity_output_oe_n_o <= !(st_q == afi_dsfid_pkg::ST_RX
					|| st_q == afi_dsfid_pkg::ST_WAIT || st_q == afi_dsfid_pkg::ST_TX);
			end else begin
				rf_activity_output_oe_n_o <= !(st_q == afi_dsfid_pkg::ST_WAIT && prog_q);
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_afi_write;
		prog_end && !nvm_fail_i && cmd_q == afi_dsfid_pkg::CMD_WRITE_AFI |=> afi_o == $past(data_q);
	endproperty
	a_afi_write: assert property (p_afi_write) else $error("afi not stored");
	property p_afi_lock;
		prog_end && !nvm_fail_i && cmd_q == afi_dsfid_pkg::CMD_LOCK_AFI |=> afi_locked_o;
	endproperty
	a_afi_lock: assert property (p_afi_lock) else $error("afi not locked");
	property p_dsfid_write;
		prog_end && !nvm_fail_i && cmd_q == afi_dsfid_pkg::CMD_WRITE_DSFID
			|=> dsfid_o == $past(data_q);
	endproperty
	a_dsfid_write: assert property (p_dsfid_write) else $error("dsfid not stored");
	property p_dsfid_lock;
		dsfid_locked_o |=> dsfid_locked_o;
	endproperty
	a_dsfid_lock: assert property (p_dsfid_lock) else $error("dsfid lock lost");
	property p_lock_blocks;
		$rose(tx_valid_o) && err_q == afi_dsfid_pkg::ERR_LOCKED |-> tx_byte_o == afi_dsfid_pkg::RESP_ERR
			&& !prog_q;
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) else $error("locked write not refused");
	property p_prog_fail;
		st_q == afi_dsfid_pkg::ST_WAIT && opt_q && prog_end && nvm_fail_i
			&& cmd_q == afi_dsfid_pkg::CMD_WRITE_AFI |=> err_q == afi_dsfid_pkg::ERR_PROG_FAIL;
	endproperty
	a_prog_fail: assert property (p_prog_fail) else $error("no 13h on failed write");
	property p_ok_len;
		$rose(tx_valid_o) && tx_byte_o == afi_dsfid_pkg::RESP_OK |-> rlen_q == afi_dsfid_pkg::LEN_RESP_OK;
	endproperty
	a_ok_len: assert property (p_ok_len) else $error("bad success length");
	property p_err_code;
		$rose(tx_valid_o) && tx_byte_o == afi_dsfid_pkg::RESP_ERR ##0 tx_ready_i
			|=> tx_byte_o == err_q && !tx_last_o;
	endproperty
	a_err_code: assert property (p_err_code) else $error("error code not second");
	property p_busy_pin;
		busy_mode_i && st_q == afi_dsfid_pkg::ST_RX ##1 busy_mode_i |-> !rf_activity_output_oe_n_o;
	endproperty
	a_busy_pin: assert property (p_busy_pin) else $error("busy pin not low");
	property p_wip_pin;
		!busy_mode_i && st_q == afi_dsfid_pkg::ST_RX ##1 !busy_mode_i |-> rf_activity_output_oe_n_o;
	endproperty
	a_wip_pin: assert property (p_wip_pin) else $error("wip pin low in request");
	property p_crc_drop;
		st_q == afi_dsfid_pkg::ST_RX && rx_eof_i && crc_q != afi_dsfid_pkg::CRC_RESIDUE
			|=> st_q == afi_dsfid_pkg::ST_IDLE ##1 !tx_valid_o;
	endproperty
	a_crc_drop: assert property (p_crc_drop) else $error("bad crc not dropped");
	property p_early_answer;
		t1_end && !opt_q |=> st_q == afi_dsfid_pkg::ST_TX && tx_valid_o;
	endproperty
	a_early_answer: assert property (p_early_answer) else $error("no answer at t1");

	c_ok_answer: cover property ($rose(tx_valid_o) && tx_byte_o == afi_dsfid_pkg::RESP_OK);
	c_err_answer: cover property ($rose(tx_valid_o) && tx_byte_o == afi_dsfid_pkg::RESP_ERR);
	c_commit: cover property (prog_end && !nvm_fail_i);
	c_drain: cover property (st_q == afi_dsfid_pkg::ST_DRAIN);
endmodule : rf_afi_dsfid_write_lock

// ### verif/rf_reader_model.sv
// reader-side model: sends request frames and takes response bytes
`timescale 1ns/1ns
module rf_reader_model (
	input  wire logic       clk_i,
	output logic            rx_sof_o,
	output logic            rx_valid_o,
	output logic [7:0]      rx_byte_o,
	output logic            rx_eof_o,
	output logic            tx_ready_o,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_byte_i,
	input  wire logic       tx_last_i
);
	initial begin
		rx_sof_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_eof_o = 1'b0;
		tx_ready_o = 1'b0;
	end

	// whole frame, one byte a cycle; the data line shows junk once released
	task automatic send(input logic [7:0] q[$]);
		@(posedge clk_i);
		#1 rx_sof_o = 1'b1;
		foreach (q[i]) begin
			@(posedge clk_i);
			#1 rx_sof_o = 1'b0;
			rx_valid_o = 1'b1;
			rx_byte_o = q[i];
		end
		@(posedge clk_i);
		#1 rx_valid_o = 1'b0;
		rx_byte_o = ~rx_byte_o;
		rx_eof_o = 1'b1;
		@(posedge clk_i);
		#1 rx_eof_o = 1'b0;
	endtask : send

	// nothing is sent while waiting, so the write cycle sees a quiet carrier
	task automatic recv(input bit slow, input int limit, output logic [7:0] q[$],
		output int dly);
		q = {};
		dly = 0;
		while (tx_valid_i !== 1'b1 && dly < limit) begin
			@(posedge clk_i);
			#1 dly++;
		end
		if (dly >= limit)
			return;
		for (int n = 0; n < 64; n++) begin
			tx_ready_o = slow ? n[0] : 1'b1;
			@(posedge clk_i);
			if (tx_valid_i === 1'b1 && tx_ready_o) begin
				q.push_back(tx_byte_i);
				if (tx_last_i === 1'b1)
					break;
			end
			#1;
		end
		#1 tx_ready_o = 1'b0;
	endtask : recv
endmodule : rf_reader_model

// ### verif/rf_afi_dsfid_write_lock_tb.sv
// self-checking bench for the afi/dsfid write and lock handler
`timescale 1ns/1ns
module rf_afi_dsfid_write_lock_tb;
	localparam int          T1  = 20;
	localparam int          WT  = 60;
	localparam logic [63:0] UID = 64'h0123_4567_89AB_CDEF; // arbitrary value
	localparam logic [7:0]  WA  = afi_dsfid_pkg::CMD_WRITE_AFI;
	localparam logic [7:0]  LA  = afi_dsfid_pkg::CMD_LOCK_AFI;
	localparam logic [7:0]  WD  = afi_dsfid_pkg::CMD_WRITE_DSFID;
	localparam logic [7:0]  LD  = afi_dsfid_pkg::CMD_LOCK_DSFID;
	logic       clk, sys_rst, rx_sof, rx_valid, rx_eof, busy_mode, nvm_fail, tx_ready;
	logic       tx_valid, tx_last, nvm_prog, afi_locked, dsfid_locked, act, act_oe_n;
	logic [7:0] rx_byte, tx_byte, afi, dsfid;
	int         errors = 0;
	int         comparisons = 0;

	always #2 clk = ~clk;

	rf_afi_dsfid_write_lock #(.T1_CYC(T1), .WT_CYC(WT)) rf_afi_dsfid_write_lock_inst (
		.clk_i(clk), .sys_rst_i(sys_rst), .rx_sof_i(rx_sof), .rx_valid_i(rx_valid),
		.rx_byte_i(rx_byte), .rx_eof_i(rx_eof), .uid_i(UID), .busy_mode_i(busy_mode),
		.nvm_fail_i(nvm_fail), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
		.tx_byte_o(tx_byte), .tx_last_o(tx_last), .nvm_prog_o(nvm_prog), .afi_o(afi),
		.dsfid_o(dsfid), .afi_locked_o(afi_locked), .dsfid_locked_o(dsfid_locked),
		.rf_activity_output_o(act), .rf_activity_output_oe_n_o(act_oe_n));

	rf_reader_model rf_reader_model_inst (
		.clk_i(clk), .rx_sof_o(rx_sof), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
		.rx_eof_o(rx_eof), .tx_ready_o(tx_ready), .tx_valid_i(tx_valid),
		.tx_byte_i(tx_byte), .tx_last_i(tx_last));

	task automatic final_report;
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	// inverted crc, sent low byte first
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = afi_dsfid_pkg::CRC_INIT;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? (c >> 1) ^ afi_dsfid_pkg::CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : crc16

	// one request and its answer; dly 0 means no answer may come
	task automatic exchange(input logic [7:0] cmd, input logic [7:0] data, input bit opt,
		input bit addr, input logic [63:0] uid, input bit bad, input bit slow,
		input logic [7:0] code, input int dly, input bit pin_low, input bit prog);
		logic [7:0]  req[$];
		logic [7:0]  rsp[$];
		logic [7:0]  exp[$];
		logic [15:0] c;
		int          seen;
		req = {8'h02 | (addr ? 8'h20 : 8'h00) | (opt ? 8'h40 : 8'h00), cmd};
		if (addr)
			for (int i = 0; i < 8; i++)
				req.push_back(uid[8*i +: 8]);
		if (cmd == WA || cmd == WD)
			req.push_back(data);
		c = crc16(req) ^ {15'h0000, bad};
		req.push_back(c[7:0]);
		req.push_back(c[15:8]);
		rf_reader_model_inst.send(req);
		fork
			rf_reader_model_inst.recv(slow, dly > 0 ? dly + 5 : WT + 10, rsp, seen);
			begin
				repeat (10) @(posedge clk);
				#1 check(act_oe_n, !pin_low);
				check(nvm_prog, prog);
				check(act, 1'b0);
			end
		join
		if (dly == 0) begin
			check(seen, WT + 10);
		end else begin
			exp = {code == 8'h00 ? afi_dsfid_pkg::RESP_OK : afi_dsfid_pkg::RESP_ERR};
			if (code != 8'h00)
				exp.push_back(code);
			c = crc16(exp);
			exp.push_back(c[7:0]);
			exp.push_back(c[15:8]);
			// dly counts from the edge that drives eof; recv starts one edge later
			check(seen, dly - 1);
			if (seen >= dly + 5)
				final_report();
			check(rsp.size(), exp.size());
			foreach (exp[i])
				check(rsp[i], exp[i]);
		end
		for (int n = 0; n < WT + 20 && (nvm_prog !== 1'b0 || tx_valid !== 1'b0); n++)
			@(posedge clk);
		if (nvm_prog !== 1'b0 || tx_valid !== 1'b0) begin
			check(nvm_prog, 0);
			final_report();
		end
		repeat (3) @(posedge clk);
		check(act_oe_n, 1);
		#1;
	endtask : exchange

	task automatic s_reset;
		check({afi, dsfid, afi_locked, dsfid_locked, act_oe_n}, 19'h00001);
	endtask : s_reset

	task automatic s_write_afi;
		busy_mode = 1'b0;
		exchange(WA, 8'h55, 0, 0, UID, 0, 0, 8'h00, T1 + 1, 1, 1);
		check({afi, dsfid}, 16'h5500);
	endtask : s_write_afi

	task automatic s_dsfid_addressed;
		busy_mode = 1'b1;
		nvm_fail = 1'b1;
		exchange(WD, 8'hA5, 1, 1, UID, 0, 0, 8'h13, WT + 1, 1, 1);
		check(dsfid, 8'h00);
		nvm_fail = 1'b0;
		exchange(WD, 8'hA5, 1, 1, UID, 0, 1, 8'h00, WT + 1, 1, 1);
		check(dsfid, 8'hA5);
	endtask : s_dsfid_addressed

	task automatic s_refused;
		busy_mode = 1'b0;
		exchange(WA, 8'h77, 0, 0, UID, 1, 0, 8'h00, 0, 0, 0);
		exchange(WA, 8'h77, 0, 1, ~UID, 0, 0, 8'h00, 0, 0, 0);
		check(afi, 8'h55);
	endtask : s_refused

	task automatic s_lock_afi;
		busy_mode = 1'b0;
		exchange(LA, 8'h00, 0, 0, UID, 0, 0, 8'h00, T1 + 1, 1, 1);
		check(afi_locked, 1);
		// a refused write must not start a write cycle nor move the pin
		exchange(WA, 8'h99, 0, 0, UID, 0, 0, 8'h12, T1 + 1, 0, 0);
		exchange(LA, 8'h00, 1, 0, UID, 0, 0, 8'h11, T1 + 1, 0, 0);
		check({afi, afi_locked}, 9'h0AB);
	endtask : s_lock_afi

	task automatic s_lock_dsfid;
		busy_mode = 1'b1;
		nvm_fail = 1'b1;
		exchange(LD, 8'h00, 1, 0, UID, 0, 0, 8'h14, WT + 1, 1, 1);
		check(dsfid_locked, 0);
		nvm_fail = 1'b0;
		exchange(LD, 8'h00, 1, 1, UID, 0, 1, 8'h00, WT + 1, 1, 1);
		check(dsfid_locked, 1);
		exchange(WD, 8'h3C, 0, 0, UID, 0, 0, 8'h12, T1 + 1, 1, 0);
		check(dsfid, 8'hA5);
	endtask : s_lock_dsfid

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		busy_mode = 1'b0;
		nvm_fail = 1'b0;
		repeat (12) @(posedge clk);
		#1 sys_rst = 1'b0;
		s_reset();
		s_write_afi();
		s_dsfid_addressed();
		s_refused();
		s_lock_afi();
		s_lock_dsfid();
		final_report();
	end
endmodule : rf_afi_dsfid_write_lock_tb
